// *** src/serial_pin_pkg.sv ***
// constants for the four-channel serial pin and receive-ready logic
// assumes one clock domain; no software-visible registers in this block
package serial_pin_pkg;
	localparam int  NUM_CH      = 4;
	localparam int  ADDR_W      = 5;
	localparam logic LINE_IDLE  = 1'h1;
	localparam logic RDY_NONE_N = 1'h1;
	localparam logic RDY_SOME_N = 1'h0;
	localparam logic STROBE_RD  = 1'h1;
	localparam logic STROBE_WR  = 1'h0;
endpackage : serial_pin_pkg

// *** src/serial_channel_pins.sv ***
// one channel: output pin drive and receive input selection
// assumes transmit path and loop-back mode come from the channel core
`timescale 1ns/100ps
`default_nettype none
module serial_channel_pins
	import serial_pin_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic tx_enable_i,
	input  wire logic tx_active_i,
	input  wire logic tx_bit_i,
	input  wire logic loopback_i,
	input  wire logic serial_in_i,
	output var  logic serial_out_o,
	output var  logic rx_line_o
);
	// ****************************************
	// pin and internal receive line
	// ****************************************
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			serial_out_o <= LINE_IDLE;
		end else if (loopback_i || !tx_enable_i || !tx_active_i) begin
			serial_out_o <= LINE_IDLE;
		end else begin
			serial_out_o <= tx_bit_i;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_line_o <= LINE_IDLE;
		end else if (loopback_i && tx_enable_i && tx_active_i) begin
			rx_line_o <= tx_bit_i;
		end else if (loopback_i) begin
			rx_line_o <= LINE_IDLE;
		end else begin
			rx_line_o <= serial_in_i;
		end
	end

	chk_loop_pin_idle: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		$past(loopback_i) |-> serial_out_o == LINE_IDLE)
		else $error("output pin active during loop-back");
	// the edge before release still holds the reset value
	chk_loop_feeds_rx: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		$past(reset_n_i) && $past(loopback_i) && $past(tx_enable_i)
		&& $past(tx_active_i) |-> rx_line_o == $past(tx_bit_i))
		else $error("loop-back receive not from transmit");
	chk_idle_out_high: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		!$past(tx_active_i) || !$past(tx_enable_i) |-> serial_out_o)
		else $error("idle output not high");
endmodule : serial_channel_pins
`default_nettype wire

// *** src/quad_serial_pins.sv ***
// top of the four-channel serial pin behaviour and shared receive-ready
// assumes per-channel transmit, loop-back and receive-status come from cores
// assumes host select, strobe and address are steady at each rising edge
`timescale 1ns/100ps
`default_nettype none
module quad_serial_pins
	import serial_pin_pkg::*;
#(
	parameter int CHANNELS = NUM_CH
)(
	input  wire logic                clk_i,
	input  wire logic                reset_n_i,
	input  wire logic [CHANNELS-1:0] tx_enable_i,
	input  wire logic [CHANNELS-1:0] tx_active_i,
	input  wire logic [CHANNELS-1:0] tx_bit_i,
	input  wire logic [CHANNELS-1:0] loopback_i,
	input  wire logic [CHANNELS-1:0] serial_in_i,
	input  wire logic [CHANNELS-1:0] per_channel_rx_avail_i,
	input  wire logic                chip_sel_n_i,
	input  wire logic                rd_wr_i,
	input  wire logic [ADDR_W-1:0]   addr_i,
	output var  logic [CHANNELS-1:0] serial_out_o,
	output var  logic [CHANNELS-1:0] rx_line_o,
	output var  logic                any_rx_data_n_o,
	output var  logic                reg_wr_o,
	output var  logic                reg_rd_o,
	output var  logic [ADDR_W-1:0]   reg_addr_o,
	output var  logic [CHANNELS-1:0] rx_status_o
);
	// ****************************************
	// channel pins
	// ****************************************
	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
		serial_channel_pins u_pins (
			.clk_i        (clk_i),
			.reset_n_i    (reset_n_i),
			.tx_enable_i  (tx_enable_i[c]),
			.tx_active_i  (tx_active_i[c]),
			.tx_bit_i     (tx_bit_i[c]),
			.loopback_i   (loopback_i[c]),
			.serial_in_i  (serial_in_i[c]),
			.serial_out_o (serial_out_o[c]),
			.rx_line_o    (rx_line_o[c])
		);
	end

	// ****************************************
	// shared receive-ready
	// ****************************************
	// the pin is active low: no data anywhere reads high
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			any_rx_data_n_o <= RDY_NONE_N;
		end else if (|per_channel_rx_avail_i) begin
			any_rx_data_n_o <= RDY_SOME_N;
		end else begin
			any_rx_data_n_o <= RDY_NONE_N;
		end
	end

	// ****************************************
	// shared receive-ready checks
	// ****************************************
	chk_ready_low: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		|per_channel_rx_avail_i |=> !any_rx_data_n_o)
		else $error("ready not low with data");

	chk_ready_high: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		per_channel_rx_avail_i == '0 |=> any_rx_data_n_o)
		else $error("ready not high when empty");

	chk_ready_combine: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		1'h1 |=> any_rx_data_n_o == !(|$past(per_channel_rx_avail_i)))
		else $error("ready not the combination of all channels");

	chk_reset_ready: assert property (@(posedge clk_i)
		!reset_n_i |-> any_rx_data_n_o == RDY_NONE_N)
		else $error("ready asserted in reset");

	// ****************************************
	// host strobe decode
	// ****************************************
	logic host_wr;
	logic host_rd;

	always_comb begin
		host_wr = !chip_sel_n_i && rd_wr_i == STROBE_WR;
		host_rd = !chip_sel_n_i && rd_wr_i == STROBE_RD;
	end

	// one strobe per cycle of select; a deselected bus gives none
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_wr_o <= '0;
			reg_rd_o <= '0;
		end else begin
			reg_wr_o <= host_wr;
			reg_rd_o <= host_rd;
		end
	end

	// address is registered every cycle so it stands with the strobe
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_addr_o <= '0;
		end else begin
			reg_addr_o <= addr_i;
		end
	end

	// status is captured only on a read and held otherwise
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_status_o <= '0;
		end else if (host_rd) begin
			rx_status_o <= per_channel_rx_avail_i;
		end
	end

	// ****************************************
	// host strobe checks
	// ****************************************
	chk_write_strobe: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		!chip_sel_n_i && !rd_wr_i |=> reg_wr_o && !reg_rd_o
		&& reg_addr_o == $past(addr_i))
		else $error("write not decoded");

	chk_read_strobe: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		!chip_sel_n_i && rd_wr_i |=> reg_rd_o && !reg_wr_o
		&& rx_status_o == $past(per_channel_rx_avail_i))
		else $error("read not decoded");

	chk_no_select: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		chip_sel_n_i |=> !reg_wr_o && !reg_rd_o)
		else $error("strobe without select");

	chk_addr_capture: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		reg_wr_o || reg_rd_o |-> reg_addr_o == $past(addr_i))
		else $error("address not captured with strobe");

	chk_status_hold: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		!reg_rd_o |-> $stable(rx_status_o))
		else $error("status changed without a read");

	chk_reset_quiet: assert property (@(posedge clk_i)
		!reset_n_i |-> !reg_wr_o && !reg_rd_o && reg_addr_o == '0
		&& rx_status_o == '0)
		else $error("host outputs not cleared in reset");

	// ****************************************
	// per-channel pin checks
	// ****************************************
	for (genvar c = 0; c < CHANNELS; c++) begin : g_chk
		chk_pin_sends: assert property (@(posedge clk_i)
			disable iff (!reset_n_i)
			tx_enable_i[c] && tx_active_i[c] && !loopback_i[c]
			|=> serial_out_o[c] == $past(tx_bit_i[c]))
			else $error("transmit bit not on output pin");

		chk_idle_pin: assert property (@(posedge clk_i)
			disable iff (!reset_n_i)
			!(tx_enable_i[c] && tx_active_i[c])
			|=> serial_out_o[c] == LINE_IDLE)
			else $error("output pin not idle without a character");

		chk_pin_to_rx: assert property (@(posedge clk_i)
			disable iff (!reset_n_i)
			!loopback_i[c] |=> rx_line_o[c] == $past(serial_in_i[c]))
			else $error("receive line not from input pin");

		chk_loop_rx_idle: assert property (@(posedge clk_i)
			disable iff (!reset_n_i)
			loopback_i[c] && !(tx_enable_i[c] && tx_active_i[c])
			|=> rx_line_o[c] == LINE_IDLE)
			else $error("loop-back receive line not idle");

		chk_loop_out_off: assert property (@(posedge clk_i)
			disable iff (!reset_n_i)
			loopback_i[c] |=> serial_out_o[c] == LINE_IDLE)
			else $error("output pin driven in loop-back");

		chk_ch_sets_ready: assert property (@(posedge clk_i)
			disable iff (!reset_n_i)
			per_channel_rx_avail_i[c] |=> any_rx_data_n_o == RDY_SOME_N)
			else $error("channel data not shown on ready");
	end

	chk_reset_pins: assert property (@(posedge clk_i)
		!reset_n_i |-> serial_out_o == '1 && rx_line_o == '1)
		else $error("pins not idle in reset");

	// ****************************************
	// scenario covers
	// ****************************************
	cov_loopback: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		|loopback_i && |tx_active_i);
	cov_ready: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		!any_rx_data_n_o ##1 any_rx_data_n_o);
	cov_write: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		reg_wr_o);
	cov_read: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		reg_rd_o && rx_status_o != '0);
	cov_loop_data: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		|(loopback_i & tx_enable_i & tx_active_i & ~tx_bit_i));
endmodule : quad_serial_pins
`default_nettype wire

// *** bench/remote_serial_end.sv ***
// far-end serial sender that feeds the four receive pins
// assumes the bench says when each channel sends and which bit
`timescale 1ns/100ps
`default_nettype none
module remote_serial_end
	import serial_pin_pkg::*;
(
	input  wire logic              reset_n_i,
	input  wire logic [NUM_CH-1:0] send_i,
	input  wire logic [NUM_CH-1:0] data_i,
	output var  logic [NUM_CH-1:0] serial_in_o
);
	// line rests high in reset and whenever not sending
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			serial_in_o[i] = LINE_IDLE;
			if (reset_n_i && send_i[i]) serial_in_o[i] = data_i[i];
		end
	end
endmodule : remote_serial_end
`default_nettype wire

// *** bench/test_quad_serial_pins.sv ***
// random stimulus checked against a cycle model of the pin logic
// assumes every output is updated at its sampling edge
`timescale 1ns/100ps
`default_nettype none
module test_quad_serial_pins;
	import serial_pin_pkg::*;
`define CHK(n,e,s) begin comparisons++; if ((s) !== (e)) begin errors++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
	logic       clk_i = 0, reset_n_i = 1, cs_n = 1, rw = 0, anyn, wr, rd;
	logic       e_any, e_wr, e_rd;
	logic [3:0] en = 0, act = 0, bv = 0, lb = 0, snd = 0, sd = 0, av = 0;
	logic [3:0] sin, sout, rxl, stat, e_out, e_rxl, e_stat;
	logic [4:0] addr = 0, raddr, e_addr;
	int         seed = 8898, errors = 0, comparisons = 0;
	quad_serial_pins quad_serial_pins_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.tx_enable_i(en), .tx_active_i(act), .tx_bit_i(bv),
		.loopback_i(lb), .serial_in_i(sin), .per_channel_rx_avail_i(av),
		.chip_sel_n_i(cs_n), .rd_wr_i(rw), .addr_i(addr),
		.serial_out_o(sout), .rx_line_o(rxl), .any_rx_data_n_o(anyn),
		.reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(raddr), .rx_status_o(stat));
	remote_serial_end remote_serial_end_i (.reset_n_i(reset_n_i),
		.send_i(snd), .data_i(sd), .serial_in_o(sin));
	initial forever #12.5 clk_i = ~clk_i;
	task automatic stop_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic do_reset;
		reset_n_i = 0;
		repeat (2) @(posedge clk_i);
		#1;
		`CHK("out", 4'hf, sout)
		`CHK("ready", RDY_NONE_N, anyn)
		`CHK("misc", 15'h7800, {rxl, wr, rd, stat, raddr})
		e_stat = '0;
		#1 reset_n_i = 1;
		$display("reset test done");
	endtask : do_reset
	task automatic run(input int n);
		repeat (n) begin
			@(posedge clk_i);
			for (int i = 0; i < NUM_CH; i++) begin
				e_out[i] = (en[i] && act[i] && !lb[i]) ? bv[i] : LINE_IDLE;
				e_rxl[i] = (en[i] && act[i]) ? bv[i] : LINE_IDLE;
				if (!lb[i]) e_rxl[i] = sin[i];
			end
			if (!cs_n && rw) e_stat = av;
			e_wr = !cs_n && rw == STROBE_WR;
			e_rd = !cs_n && rw == STROBE_RD;
			e_addr = addr;
			e_any = (av == 0) ? RDY_NONE_N : RDY_SOME_N;
			#1;
			`CHK("serial_out", e_out, sout)
			`CHK("rx_line", e_rxl, rxl)
			`CHK("ready", e_any, anyn)
			`CHK("write", e_wr, wr)
			`CHK("read", e_rd, rd)
			`CHK("addr", e_addr, raddr)
			`CHK("status", e_stat, stat)
			#1;
			{en, act, bv, lb} = 16'($random(seed));
			{snd, sd} = 8'($random(seed));
			av = 4'($random(seed) & $random(seed));
			{cs_n, rw, addr} = 7'($random(seed));
		end
	endtask : run
	initial begin
		#(25 * 2000);
		errors++;
		stop_test();
	end
	initial begin
		#2;
		do_reset();
		run(600);
		do_reset();
		run(300);
		$display("random test done");
		stop_test();
	end
endmodule : test_quad_serial_pins
`default_nettype wire
